/* verilog/sfcmd_consts.svh */
// Constants for the serial flash status, ID and power command block
`ifndef SFCMD_CONSTS_SVH
`define SFCMD_CONSTS_SVH

`define SFCMD_OP_WRSR1 8'h01
`define SFCMD_OP_WRSR2 8'h31
`define SFCMD_OP_ID 8'h9F
`define SFCMD_OP_DPD 8'hB9
`define SFCMD_OP_RES 8'hAB
`define SFCMD_BIT_LOCK 7
`define SFCMD_GP_HI 5
`define SFCMD_GP_LO 2
`define SFCMD_BIT_PERMIT 4
`define SFCMD_ID_LEN_BYTE 8'h00
`define SFCMD_ID_BYTES 3'h4
`define SFCMD_BIT_LAST 3'h7
`define SFCMD_ENTER_NS 3000
`define SFCMD_RESUME_NS 8000
`define SFCMD_CLK_NS 100
// Longest delays round down, never below one cycle
`define SFCMD_ENTER_CYC ((`SFCMD_ENTER_NS / `SFCMD_CLK_NS) < 1 ? 1 : \
  (`SFCMD_ENTER_NS / `SFCMD_CLK_NS))
`define SFCMD_RESUME_CYC ((`SFCMD_RESUME_NS / `SFCMD_CLK_NS) < 1 ? 1 : \
  (`SFCMD_RESUME_NS / `SFCMD_CLK_NS))
`define SFCMD_MAKER_CODE 8'hA5
`define SFCMD_FAMILY 3'h3
`define SFCMD_DENSITY 5'h05
`define SFCMD_SUBSERIES 3'h1
`define SFCMD_VERSION 5'h03

`endif

/* verilog/sfcmd_pkg.sv */
// Types for the serial flash command block
package sfcmd_pkg;
  typedef enum logic [2:0] {
    SFCMD_OPCODE,
    SFCMD_WRSR1,
    SFCMD_WRSR2,
    SFCMD_IDREAD,
    SFCMD_IGNORE
  } sfcmd_phase_t;

  typedef enum logic [1:0] {
    SFCMD_STANDBY,
    SFCMD_ENTERING,
    SFCMD_POWERDOWN,
    SFCMD_RESUMING
  } sfcmd_power_t;
endpackage

/* verilog/sfcmd_sync.sv */
// Two-flop synchroniser for one level from outside the clock domain
`timescale 1ns/10ps
module sfcmd_sync (
  input wire logic sys_clk, // System clock
  input wire logic rst_n, // Asynchronous reset, active low
  input wire logic clk_en, // Clock enable
  input wire logic rst_val, // Value held during reset
  input wire logic async_in, // Unsynchronised level
  output logic sync_out // Synchronised level
);
  logic stage1_ff;
  logic sync_ff;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      stage1_ff <= 1'b0;
      sync_ff <= 1'b0;
    end else if (clk_en) begin
      stage1_ff <= async_in ^ rst_val;
      sync_ff <= stage1_ff;
    end
  end

  assign sync_out = sync_ff ^ rst_val;
endmodule

/* verilog/sfcmd_delay.sv */
// Down counter that signals when a power transition delay has run out
`timescale 1ns/10ps
module sfcmd_delay (
  input wire logic sys_clk, // System clock
  input wire logic rst_n, // Asynchronous reset, active low
  input wire logic clk_en, // Clock enable
  input wire logic start, // Load the count, one-cycle pulse
  input wire logic [15:0] length, // Cycles to count
  output logic busy, // Count running
  output logic done // Count expired, one-cycle pulse
);
  logic [15:0] count_ff;
  logic done_ff;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      count_ff <= 16'h0000;
      done_ff <= 1'b0;
    end else if (clk_en) begin
      done_ff <= 1'b0;
      if (start) begin
        count_ff <= length;
      end else if (count_ff != 16'h0000) begin
        count_ff <= count_ff - 16'h0001;
        if (count_ff == 16'h0001) begin
          done_ff <= 1'b1;
        end
      end
    end
  end

  assign busy = (count_ff != 16'h0000) || start;
  assign done = done_ff;
endmodule

/* verilog/sfcmd_core.sv */
// Serial flash command interpreter: status writes, ID read, deep power-down
`timescale 1ns/10ps
`include "sfcmd_consts.svh"
module sfcmd_core #(
  parameter logic [15:0] ENTER_CYCLES = 16'(`SFCMD_ENTER_CYC),
  parameter logic [15:0] RESUME_CYCLES = 16'(`SFCMD_RESUME_CYC)
) (
  input wire logic sys_clk, // System clock, 10 MHz
  input wire logic rst_n, // Asynchronous reset, active low
  input wire logic clk_en, // Freezes all state while low
  input wire logic cs_n, // Chip select pin, active low
  input wire logic sck, // Serial clock pin
  input wire logic si, // Serial data in pin
  output logic so_out, // Serial data out value
  output logic so_oe, // Serial data out enable
  input wire logic wp_n, // Write-protect pin, active low
  input wire logic wr_en_done, // Write enable command done, pulse
  input wire logic op_busy, // Self-timed program or erase running
  output logic write_enable_latch, // Latch state
  output logic protect_lock_bit, // Protection lock state
  output logic soft_reset_permit, // Reset command permit
  output logic global_req, // Global protect decision request, pulse
  output logic [3:0] global_code, // Protect code for the request
  output logic global_prior_lock, // Lock value before the write
  output logic deep_powerdown, // Device in deep power-down
  output logic standby // Deselected, idle and powered up
);
  // ==========================================================
  // Pin synchronisers
  logic cs_n_s;
  logic sck_s;
  logic si_s;
  logic wp_n_s;

  sfcmd_sync u_sync_cs (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en),
    .rst_val(1'b1), .async_in(cs_n), .sync_out(cs_n_s));
  sfcmd_sync u_sync_sck (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en),
    .rst_val(1'b0), .async_in(sck), .sync_out(sck_s));
  sfcmd_sync u_sync_si (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en),
    .rst_val(1'b0), .async_in(si), .sync_out(si_s));
  sfcmd_sync u_sync_wp (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en),
    .rst_val(1'b1), .async_in(wp_n), .sync_out(wp_n_s));

  // ==========================================================
  // Edge detection
  logic sck_d_ff;
  logic cs_n_d_ff;
  logic sck_rise;
  logic sck_fall;
  logic cs_rise;
  logic cs_fall;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sck_d_ff <= 1'b0;
      cs_n_d_ff <= 1'b1;
    end else if (clk_en) begin
      sck_d_ff <= sck_s;
      cs_n_d_ff <= cs_n_s;
    end
  end

  assign sck_rise = sck_s && !sck_d_ff && !cs_n_s;
  assign sck_fall = !sck_s && sck_d_ff && !cs_n_s;
  assign cs_rise = cs_n_s && !cs_n_d_ff;
  assign cs_fall = !cs_n_s && cs_n_d_ff;

  // ==========================================================
  // Bit and byte framing
  logic [2:0] bit_cnt_ff;
  logic [7:0] shift_ff;
  logic byte_done;
  logic [7:0] byte_val;
  logic [2:0] byte_cnt_ff;
  logic aligned;

  assign byte_done = sck_rise && (bit_cnt_ff == `SFCMD_BIT_LAST);
  assign byte_val = {shift_ff[6:0], si_s};
  assign aligned = (bit_cnt_ff == 3'h0);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      bit_cnt_ff <= 3'h0;
      shift_ff <= 8'h00;
    end else if (clk_en) begin
      if (cs_fall) begin
        bit_cnt_ff <= 3'h0;
      end else if (sck_rise) begin
        bit_cnt_ff <= bit_cnt_ff + 3'h1;
        shift_ff <= byte_val;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      byte_cnt_ff <= 3'h0;
    end else if (clk_en) begin
      if (cs_fall) begin
        byte_cnt_ff <= 3'h0;
      end else if (byte_done && byte_cnt_ff != 3'h7) begin
        byte_cnt_ff <= byte_cnt_ff + 3'h1;
      end
    end
  end

  // ==========================================================
  // Power state and delay counter
  sfcmd_pkg::sfcmd_power_t pwr_ff;
  sfcmd_pkg::sfcmd_power_t nxt_pwr;
  logic dly_start;
  logic [15:0] dly_len;
  logic dly_busy;
  logic dly_done;
  logic dpd_commit;
  logic res_commit;

  sfcmd_delay u_delay (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en),
    .start(dly_start), .length(dly_len), .busy(dly_busy), .done(dly_done));

  // ==========================================================
  // Command phase
  sfcmd_pkg::sfcmd_phase_t phase_ff;
  logic [7:0] opcode_ff;
  logic [7:0] data_ff;
  logic data_ok_ff;
  logic frame_ok_ff;

  function automatic logic cmd_allowed(input sfcmd_pkg::sfcmd_power_t p,
                                       input logic [7:0] op);
    case (p)
      sfcmd_pkg::SFCMD_STANDBY: cmd_allowed = 1'b1;
      sfcmd_pkg::SFCMD_POWERDOWN: cmd_allowed = (op == `SFCMD_OP_RES);
      default: cmd_allowed = 1'b0;
    endcase
  endfunction

  // A frame that starts during a transition is ignored to its end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      frame_ok_ff <= 1'b0;
    end else if (clk_en) begin
      if (cs_fall) begin
        frame_ok_ff <= (pwr_ff == sfcmd_pkg::SFCMD_STANDBY) ||
                       (pwr_ff == sfcmd_pkg::SFCMD_POWERDOWN);
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_ff <= sfcmd_pkg::SFCMD_OPCODE;
      opcode_ff <= 8'h00;
    end else if (clk_en) begin
      if (cs_fall) begin
        phase_ff <= sfcmd_pkg::SFCMD_OPCODE;
        opcode_ff <= 8'h00;
      end else if (byte_done) begin
        case (phase_ff)
          sfcmd_pkg::SFCMD_OPCODE: begin
            opcode_ff <= byte_val;
            if (!frame_ok_ff || !cmd_allowed(pwr_ff, byte_val)) begin
              phase_ff <= sfcmd_pkg::SFCMD_IGNORE;
            end else begin
              case (byte_val)
                `SFCMD_OP_WRSR1: phase_ff <= sfcmd_pkg::SFCMD_WRSR1;
                `SFCMD_OP_WRSR2: phase_ff <= sfcmd_pkg::SFCMD_WRSR2;
                `SFCMD_OP_ID: phase_ff <= sfcmd_pkg::SFCMD_IDREAD;
                default: phase_ff <= sfcmd_pkg::SFCMD_IGNORE;
              endcase
            end
          end
          sfcmd_pkg::SFCMD_WRSR1,
          sfcmd_pkg::SFCMD_WRSR2: phase_ff <= sfcmd_pkg::SFCMD_IGNORE;
          sfcmd_pkg::SFCMD_IDREAD: phase_ff <= sfcmd_pkg::SFCMD_IDREAD;
          default: phase_ff <= sfcmd_pkg::SFCMD_IGNORE;
        endcase
      end
    end
  end

  // First data byte only; later bytes are discarded
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      data_ff <= 8'h00;
      data_ok_ff <= 1'b0;
    end else if (clk_en) begin
      if (cs_fall) begin
        data_ok_ff <= 1'b0;
      end else if (byte_done && (phase_ff == sfcmd_pkg::SFCMD_WRSR1 ||
                                 phase_ff == sfcmd_pkg::SFCMD_WRSR2)) begin
        data_ff <= byte_val;
        data_ok_ff <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Commit at deselect
  logic wr1_seen;
  logic wr2_seen;
  logic wr1_full;
  logic wr2_full;
  logic wr_lock_clear;
  logic latch_clear;

  // Opcode taken when the opcode byte was allowed in this power state
  assign wr1_seen = cs_rise && frame_ok_ff && (pwr_ff ==
    sfcmd_pkg::SFCMD_STANDBY) && (opcode_ff == `SFCMD_OP_WRSR1) &&
    (byte_cnt_ff != 3'h0);
  assign wr2_seen = cs_rise && frame_ok_ff && (pwr_ff ==
    sfcmd_pkg::SFCMD_STANDBY) && (opcode_ff == `SFCMD_OP_WRSR2) &&
    (byte_cnt_ff != 3'h0);
  // Second write also needs a byte-aligned deselect
  assign wr1_full = wr1_seen && data_ok_ff && write_enable_latch;
  assign wr2_full = wr2_seen && data_ok_ff && aligned &&
                    write_enable_latch;
  assign wr_lock_clear = protect_lock_bit && !data_ff[`SFCMD_BIT_LOCK];
  assign latch_clear = wr1_seen || wr2_seen;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      write_enable_latch <= 1'b0;
    end else if (clk_en) begin
      if (wr_en_done && !(pwr_ff == sfcmd_pkg::SFCMD_POWERDOWN)) begin
        write_enable_latch <= 1'b1; // Set wins over clear
      end else if (latch_clear) begin
        write_enable_latch <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      protect_lock_bit <= 1'b0;
    end else if (clk_en) begin
      // Write-protect pin lets the lock only be set
      if (wr1_full && !(wr_lock_clear && !wp_n_s)) begin
        protect_lock_bit <= data_ff[`SFCMD_BIT_LOCK];
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      global_req <= 1'b0;
      global_code <= 4'h0;
      global_prior_lock <= 1'b0;
    end else if (clk_en) begin
      global_req <= wr1_full && !(wr_lock_clear && !wp_n_s);
      if (wr1_full) begin
        global_code <= data_ff[`SFCMD_GP_HI:`SFCMD_GP_LO];
        global_prior_lock <= protect_lock_bit;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      soft_reset_permit <= 1'b0;
    end else if (clk_en) begin
      if (wr2_full) begin
        soft_reset_permit <= data_ff[`SFCMD_BIT_PERMIT];
      end
    end
  end

  // ==========================================================
  // Power sequencing
  assign dpd_commit = cs_rise && frame_ok_ff && aligned && !op_busy &&
    (pwr_ff == sfcmd_pkg::SFCMD_STANDBY) && (byte_cnt_ff != 3'h0) &&
    (opcode_ff == `SFCMD_OP_DPD);
  assign res_commit = cs_rise && frame_ok_ff && aligned &&
    (pwr_ff == sfcmd_pkg::SFCMD_POWERDOWN) && (byte_cnt_ff != 3'h0) &&
    (opcode_ff == `SFCMD_OP_RES);

  always_comb begin
    nxt_pwr = pwr_ff;
    dly_start = 1'b0;
    dly_len = ENTER_CYCLES;
    case (pwr_ff)
      sfcmd_pkg::SFCMD_STANDBY: begin
        if (dpd_commit) begin
          nxt_pwr = sfcmd_pkg::SFCMD_ENTERING;
          dly_start = 1'b1;
        end
      end
      sfcmd_pkg::SFCMD_ENTERING: begin
        if (dly_done) begin
          nxt_pwr = sfcmd_pkg::SFCMD_POWERDOWN;
        end
      end
      sfcmd_pkg::SFCMD_POWERDOWN: begin
        if (res_commit) begin
          nxt_pwr = sfcmd_pkg::SFCMD_RESUMING;
          dly_start = 1'b1;
          dly_len = RESUME_CYCLES;
        end
      end
      sfcmd_pkg::SFCMD_RESUMING: begin
        if (dly_done) begin
          nxt_pwr = sfcmd_pkg::SFCMD_STANDBY;
        end
      end
      default: nxt_pwr = sfcmd_pkg::SFCMD_STANDBY;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pwr_ff <= sfcmd_pkg::SFCMD_STANDBY;
    end else if (clk_en) begin
      pwr_ff <= nxt_pwr;
    end
  end

  assign deep_powerdown = (pwr_ff == sfcmd_pkg::SFCMD_POWERDOWN) ||
                          (pwr_ff == sfcmd_pkg::SFCMD_ENTERING);
  assign standby = cs_n_s && !op_busy && !dly_busy &&
                   (pwr_ff == sfcmd_pkg::SFCMD_STANDBY);

  // ==========================================================
  // Identification output
  logic [7:0] id_byte;
  logic so_ff;
  logic so_oe_ff;

  function automatic logic [7:0] id_lookup(input logic [2:0] idx);
    case (idx)
      3'h0: id_lookup = `SFCMD_MAKER_CODE; // Arbitrary maker code
      3'h1: id_lookup = {`SFCMD_FAMILY, `SFCMD_DENSITY};
      3'h2: id_lookup = {`SFCMD_SUBSERIES, `SFCMD_VERSION};
      default: id_lookup = `SFCMD_ID_LEN_BYTE;
    endcase
  endfunction

  // byte_cnt counts the opcode too, so data byte n is count n+1
  assign id_byte = id_lookup(byte_cnt_ff - 3'h1);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      so_ff <= 1'b0;
      so_oe_ff <= 1'b0;
    end else if (clk_en) begin
      if (cs_n_s) begin
        so_oe_ff <= 1'b0;
      end else if (sck_fall) begin
        if (phase_ff == sfcmd_pkg::SFCMD_IDREAD && byte_cnt_ff != 3'h0 &&
            byte_cnt_ff <= `SFCMD_ID_BYTES) begin
          so_ff <= id_byte[3'h7 - bit_cnt_ff];
          so_oe_ff <= 1'b1;
        end else begin
          so_oe_ff <= 1'b0;
        end
      end
    end
  end

  assign so_out = so_ff;
  assign so_oe = so_oe_ff;
endmodule

/* tb/sfcmd_checker.sv */
// Concurrent checks on the ports of the serial flash command block
`timescale 1ns/10ps
module sfcmd_checker #(
  parameter logic [15:0] ENTER_CYCLES = 16'h001E,
  parameter logic [15:0] RESUME_CYCLES = 16'h0050
) (
  input wire logic sys_clk, // System clock
  input wire logic rst_n, // Reset, active low
  input wire logic cs_n, // Chip select, active low
  input wire logic wp_n, // Write protect, active low
  input wire logic clk_en, // Clock enable
  input wire logic wr_en_done, // Write enable pulse
  input wire logic op_busy, // Program or erase running
  input wire logic so_oe, // Serial out enable
  input wire logic write_enable_latch, // Latch
  input wire logic protect_lock_bit, // Lock
  input wire logic soft_reset_permit, // Reset permit
  input wire logic global_req, // Global protect request
  input wire logic global_prior_lock, // Lock before write
  input wire logic deep_powerdown, // In power-down
  input wire logic standby // Idle
);
  logic dp_ff;
  logic [15:0] res_cnt_ff;
  logic [15:0] nxt_res_cnt;
  // ========================================
  // Resume length, counted from the fall of power-down
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) dp_ff <= 1'b0;
    else dp_ff <= deep_powerdown;
  end
  always_comb begin
    nxt_res_cnt = 16'h0000;
    if (dp_ff && !deep_powerdown) nxt_res_cnt = 16'h0001;
    else if (res_cnt_ff != 16'h0000 && !standby)
      nxt_res_cnt = res_cnt_ff + 16'h0001;
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) res_cnt_ff <= 16'h0000;
    else res_cnt_ff <= nxt_res_cnt;
  end
  // ========================================
  // Properties
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  sequence s_cs_idle; cs_n [*4]; endsequence
  sequence s_cs_busy; !cs_n [*4]; endsequence
  sequence s_wp_held; !wp_n [*6]; endsequence
  AST_OE_IDLE: assert property (s_cs_idle |-> !so_oe)
    else $error("output enabled while deselected");
  AST_NO_STANDBY_SEL: assert property (s_cs_busy |-> !standby)
    else $error("standby while selected");
  // A running block in standby must take the write enable pulse
  AST_LATCH_SET: assert property (wr_en_done && standby && clk_en |=>
    write_enable_latch)
    else $error("latch not set by write enable");
  AST_LOCK_REQ: assert property ($changed(protect_lock_bit) |->
    global_req)
    else $error("lock changed without request");
  AST_REQ_LATCH: assert property (global_req |->
    !write_enable_latch && $past(write_enable_latch))
    else $error("status write without latch or latch kept");
  AST_REQ_PRIOR: assert property (global_req |->
    global_prior_lock == $past(protect_lock_bit))
    else $error("prior lock wrong");
  AST_WP_KEEP: assert property (s_wp_held ##0 protect_lock_bit |=>
    protect_lock_bit)
    else $error("lock cleared under write protect");
  AST_PERMIT_LATCH: assert property ($changed(soft_reset_permit) |->
    $past(write_enable_latch) && !write_enable_latch)
    else $error("permit changed without latch");
  AST_PD_FREEZE: assert property (deep_powerdown |=>
    $stable(protect_lock_bit) && $stable(soft_reset_permit) && !so_oe)
    else $error("activity in power-down");
  AST_PD_BUSY: assert property ($rose(deep_powerdown) |->
    !$past(op_busy))
    else $error("power-down entered while busy");
  AST_RESUME_LEN: assert property (res_cnt_ff <=
    RESUME_CYCLES + 16'h0004)
    else $error("resume too long");
endmodule

/* tb/sfcmd_host.sv */
// Behavioural SPI host model, mode 0, for the command block
`timescale 1ns/10ps
module sfcmd_host (
  input wire logic sys_clk, // System clock
  output logic cs_n, // Chip select, active low
  output logic sck, // Serial clock
  output logic si, // Serial data to the device
  input wire logic so_out, // Serial data from the device
  input wire logic so_oe // Device drives serial out
);
  logic rx_d [64];
  logic rx_oe [64];
  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    si = 1'b0;
  end
  // ========================================
  // One frame; the clock stands low outside frames
  // Slow fixed clock of 800 ns suits the ID read too
  task automatic frame(input logic [63:0] tx, input int nbits);
    @(negedge sys_clk) cs_n = 1'b0;
    repeat (4) @(negedge sys_clk);
    for (int i = 0; i < nbits; i++) begin
      sck = 1'b0;
      si = tx[63 - i];
      repeat (4) @(negedge sys_clk);
      sck = 1'b1;
      repeat (4) @(negedge sys_clk);
      rx_d[i] = so_out;
      rx_oe[i] = so_oe;
    end
    sck = 1'b0;
    repeat (4) @(negedge sys_clk);
    cs_n = 1'b1;
    si = ~si;
  endtask
endmodule

/* tb/tb_spi_flash_status_id_power_cmds.sv */
// Self-checking bench for the serial flash command block
`timescale 1ns/10ps
`include "sfcmd_consts.svh"
module tb_spi_flash_status_id_power_cmds;
  localparam logic [15:0] ENTER_CYCLES = 16'h0004;
  localparam logic [15:0] RESUME_CYCLES = 16'h0006;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic wp_n = 1'b1;
  logic wr_en_done = 1'b0;
  logic clk_en = 1'b1;
  logic op_busy = 1'b0;
  logic cs_n, sck, si, so_out, so_oe, latch, lock, permit;
  logic [7:0] r_op;
  logic greq, gprior, dpd, stby;
  logic [3:0] gcode;
  logic [3:0] gr_code;
  logic gr_prior;
  int num_errors = 0;
  int n_compared = 0;
  int seed = 87925;
  int gr_n = 0;
  int m_latch = 0, m_lock = 0, m_permit = 0, m_pd = 0, m_gr = 0;
  always #50 sys_clk = ~sys_clk;
  sfcmd_core #(.ENTER_CYCLES(ENTER_CYCLES), .RESUME_CYCLES(RESUME_CYCLES))
    dut (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en), .cs_n(cs_n),
    .sck(sck), .si(si), .so_out(so_out), .so_oe(so_oe), .wp_n(wp_n),
    .wr_en_done(wr_en_done), .op_busy(op_busy),
    .write_enable_latch(latch),
    .protect_lock_bit(lock), .soft_reset_permit(permit),
    .global_req(greq), .global_code(gcode), .global_prior_lock(gprior),
    .deep_powerdown(dpd), .standby(stby));
  sfcmd_host host (.sys_clk(sys_clk), .cs_n(cs_n), .sck(sck), .si(si),
    .so_out(so_out), .so_oe(so_oe));
  // Sampled off the launching edge so the pulse is seen settled
  always @(negedge sys_clk) begin
    if (greq === 1'b1) begin
      gr_n++;
      gr_code = gcode;
      gr_prior = gprior;
    end
  end
  // ========================================
  // Checking helpers and the host-side command model
  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic stop_test;
    if (num_errors == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic set_latch;
    @(negedge sys_clk) wr_en_done = 1'b1;
    @(negedge sys_clk) wr_en_done = 1'b0;
    if (m_pd == 0) m_latch = 1;
  endtask
  task automatic state_chk;
    chk("write_enable_latch", m_latch, latch);
    chk("protect_lock_bit", m_lock, lock);
    chk("soft_reset_permit", m_permit, permit);
    chk("deep_powerdown", m_pd, dpd);
    chk("standby", m_pd == 0 && op_busy == 0, stby);
    chk("so_oe", 0, so_oe);
    chk("global_req count", m_gr, gr_n);
  endtask
  task automatic cmd(input logic [7:0] op, input logic [7:0] d,
                     input int nbits);
    bit al, id, gq;
    int pl;
    logic [31:0] idv;
    al = (nbits % 8 == 0) && nbits >= 8;
    id = (op == 8'h9F) && m_pd == 0;
    gq = 0;
    pl = m_lock;
    idv = {`SFCMD_MAKER_CODE, `SFCMD_FAMILY, `SFCMD_DENSITY,
           `SFCMD_SUBSERIES, `SFCMD_VERSION, `SFCMD_ID_LEN_BYTE};
    host.frame({op, d, ~d, 40'h0}, nbits);
    if (m_pd != 0) begin
      if (op == 8'hAB && al) m_pd = 0;
    end else if (op == 8'h01 && m_latch != 0) begin
      if (nbits >= 16 && !(wp_n == 0 && d[7] == 0 && m_lock == 1)) begin
        m_lock = d[7];
        m_gr++;
        gq = 1;
      end
      m_latch = 0;
    end else if (op == 8'h31 && m_latch != 0) begin
      if (nbits >= 16 && al) m_permit = d[4];
      m_latch = 0;
    end else if (op == 8'hB9 && al && op_busy == 0) m_pd = 1;
    repeat (30) @(negedge sys_clk);
    for (int i = 0; i < nbits; i++) begin
      chk("so_oe in frame", id && i >= 8 && i < 40, host.rx_oe[i]);
      if (id && i >= 8 && i < 40) chk("so_out", idv[39 - i], host.rx_d[i]);
    end
    state_chk();
    if (gq) begin
      chk("global_code", d[5:2], gr_code);
      chk("global_prior_lock", pl, gr_prior);
    end
  endtask
  // ========================================
  // Main sequence
  initial begin
    repeat (60000) @(posedge sys_clk);
    num_errors++;
    stop_test();
  end
  initial begin
    repeat (12) @(negedge sys_clk);
    chk("standby in reset", 1, stby);
    rst_n = 1'b1;
    repeat (6) @(negedge sys_clk);
    state_chk();
    cmd(8'h01, 8'h80, 16);
    set_latch();
    cmd(8'h01, 8'hBC, 16);
    wp_n = 1'b0;
    set_latch();
    cmd(8'h01, 8'h3C, 16);
    set_latch();
    cmd(8'h01, 8'h84, 12);
    for (int k = 0; k < 8; k++) begin
      wp_n = 1'($random(seed));
      set_latch();
      r_op = (k % 2) ? 8'h01 : 8'h31;
      cmd(r_op, 8'($random(seed)), 16 + 8 * (k % 3));
    end
    wp_n = 1'b1;
    set_latch();
    cmd(8'h31, 8'hEF, 20);
    set_latch();
    cmd(8'h31, 8'h10, 12);
    cmd(8'h31, 8'h10, 16);
    cmd(8'h9F, 8'h00, 48);
    cmd(8'h9F, 8'h00, 20);
    op_busy = 1'b1;
    cmd(8'hB9, 8'h00, 8);
    op_busy = 1'b0;
    cmd(8'hB9, 8'h00, 12);
    cmd(8'hB9, 8'h00, 4);
    cmd(8'hB9, 8'h55, 16);
    set_latch();
    cmd(8'h01, 8'h80, 16);
    cmd(8'h9F, 8'h00, 48);
    cmd(8'hAB, 8'h00, 4);
    cmd(8'hAB, 8'h00, 12);
    cmd(8'hAB, 8'h55, 16);
    // Clock enable low: the write enable pulse must be lost
    clk_en = 1'b0;
    @(negedge sys_clk) wr_en_done = 1'b1;
    @(negedge sys_clk) wr_en_done = 1'b0;
    clk_en = 1'b1;
    repeat (4) @(negedge sys_clk);
    state_chk();
    set_latch();
    cmd(8'h31, 8'hFF, 16);
    stop_test();
  end
endmodule
bind sfcmd_core sfcmd_checker #(.ENTER_CYCLES(ENTER_CYCLES),
  .RESUME_CYCLES(RESUME_CYCLES)) u_chk (.sys_clk(sys_clk), .rst_n(rst_n),
  .cs_n(cs_n), .wp_n(wp_n), .clk_en(clk_en), .wr_en_done(wr_en_done),
  .op_busy(op_busy),
  .so_oe(so_oe), .write_enable_latch(write_enable_latch),
  .protect_lock_bit(protect_lock_bit),
  .soft_reset_permit(soft_reset_permit), .global_req(global_req),
  .global_prior_lock(global_prior_lock), .deep_powerdown(deep_powerdown),
  .standby(standby));
